// >>> hdl/tsp_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01: Reset clears state, starts continuous conversion
// R02: Output invalid until first conversion done
// R03: Temperature is 14-bit two's complement
// R04: Word bits 15:2 temperature, 1:0 ones
// R05: Shift out MSB first
// R06: Drive on falling, sample on rising
// R07: Host keeps chip select high between frames
// R08: Sixteen clocks out, then sixteen in
// R09: Release data pin while deselected
// R10: First bit driven right at select
// R11: Host avoids select during rising clock
// R12: Raising select mid-output ends cleanly
// R13: Conversion finishes; load deferred until deselect
// R14: Receive into 8-bit register, act on deselect
// R15: 00 runs, FF shuts down
// R16: Host sends only the two commands
// R17: Shutdown reads return identification word
// R18: Leading five ID bits name maker
// R19: Read, shutdown, read ID, resume in frame
// R20: Host waits one conversion after resuming
// R21: Temp and ID read-only, config write-only
// R22: Chip select is active low
// R23: Conversions back to back, results replace register
module tsp_port #(
  parameter int CONV_CYCLES = tsp_pkg::CONV_CYCLES,
  parameter logic [15:0] ID_WORD = tsp_pkg::ID_WORD_RST
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic chip_sel_n,
  input wire logic serial_bit_clock,
  input wire logic sio_in,
  output logic sio_out,
  output logic sio_oe,
  input wire logic [tsp_pkg::TEMP_W-1:0] sensor_sample,
  output logic shutdown,
  output logic temp_valid
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OUT = 3'b010,
    ST_IN = 3'b100
  } tsp_state_t;

  logic cs_n_s;
  logic sck_s;
  logic din_s;
  logic sck_d;
  logic cs_d;
  logic next_sck_d;
  logic next_cs_d;
  logic conv_done;
  logic [tsp_pkg::TEMP_W-1:0] conv_result;

  tsp_state_t state;
  tsp_state_t next_state;
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic [4:0] bitcnt;
  logic [4:0] next_bitcnt;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [15:0] temperature_result;
  logic [15:0] next_temperature_result;
  logic pend;
  logic next_pend;
  logic next_shutdown;
  logic next_temp_valid;
  logic next_sio_out;
  logic next_sio_oe;

  tsp_sync u_cs (
    .clk(clk),
    .srst(srst),
    .din(chip_sel_n),
    .rst_val(1'b1),
    .dout(cs_n_s)
  );

  tsp_sync u_sck (
    .clk(clk),
    .srst(srst),
    .din(serial_bit_clock),
    .rst_val(1'b0),
    .dout(sck_s)
  );

  tsp_sync u_din (
    .clk(clk),
    .srst(srst),
    .din(sio_in),
    .rst_val(1'b0),
    .dout(din_s)
  );

  tsp_converter #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .clk(clk),
    .srst(srst),
    .run(~shutdown),
    .sample(sensor_sample),
    .done(conv_done),
    .result(conv_result)
  );

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic [15:0] load_word;
  logic [15:0] fresh_word;

  assign sck_rise = sck_s && !sck_d; // [R06]
  assign sck_fall = !sck_s && sck_d; // [R06]
  assign cs_fall = !cs_n_s && cs_d; // [R22]
  assign cs_rise = cs_n_s && !cs_d;
  assign fresh_word = {conv_result, tsp_pkg::WORD_TAIL}; // [R03] [R04]
  assign load_word = shutdown ? ID_WORD : temperature_result; // [R17] [R18] [R21]

  always_comb begin
    next_sck_d = srst ? 1'b0 : sck_s;
    next_cs_d = srst ? 1'b1 : cs_n_s;
    next_state = state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_cmd = cmd;
    next_temperature_result = temperature_result;
    next_pend = pend;
    next_shutdown = shutdown;
    next_temp_valid = temp_valid;
    next_sio_out = sio_out;
    next_sio_oe = sio_oe;
    // Result stays parked while selected so the word being shifted cannot tear
    if (conv_done) begin
      next_temp_valid = 1'b1; // [R02]
      if (cs_n_s && !pend) begin
        next_temperature_result = fresh_word; // [R23]
      end else begin
        next_pend = 1'b1; // [R13]
      end
    end
    if (pend && cs_n_s) begin
      next_temperature_result = fresh_word; // [R13]
      next_pend = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        next_sio_oe = 1'b0; // [R09]
        if (cs_fall) begin
          next_state = ST_OUT;
          next_sio_oe = 1'b1;
          next_sio_out = load_word[15]; // [R10] [R05]
          next_shreg = {load_word[14:0], 1'b1};
          next_bitcnt = '0;
        end
      end
      ST_OUT: begin
        if (cs_n_s) begin
          next_state = ST_IDLE; // [R12]
          next_sio_oe = 1'b0;
        end else begin
          if (sck_rise) begin
            next_bitcnt = bitcnt + 5'h1;
          end
          if (sck_fall && bitcnt != 5'h0) begin
            if (bitcnt == 5'(tsp_pkg::PHASE_BITS)) begin
              next_state = ST_IN; // [R08]
              next_sio_oe = 1'b0;
              next_bitcnt = '0;
            end else begin
              next_sio_out = shreg[15]; // [R05] [R06]
              next_shreg = {shreg[14:0], 1'b1};
            end
          end
        end
      end
      ST_IN: begin
        next_sio_oe = 1'b0;
        if (cs_n_s) begin
          next_state = ST_IDLE;
          if (bitcnt >= 5'(tsp_pkg::CMD_W)) begin
            // Other codes would enter test modes; they are ignored here
            if (cmd == tsp_pkg::CMD_RUN) begin
              next_shutdown = 1'b0; // [R14] [R15]
            end else if (cmd == tsp_pkg::CMD_SHUTDOWN) begin
              next_shutdown = 1'b1; // [R15]
            end
          end
        end else if (sck_rise && bitcnt != 5'(tsp_pkg::PHASE_BITS)) begin
          next_cmd = {cmd[6:0], din_s}; // [R14]
          next_bitcnt = bitcnt + 5'h1;
        end
        // Mid-frame mode change lets a second read see the ID word
        if (!cs_n_s && sck_fall && bitcnt == 5'(tsp_pkg::PHASE_BITS)) begin
          next_state = ST_OUT; // [R19]
          // Counting restarts from zero so the sixteenth falling edge hands over again
          next_bitcnt = '0;
          next_sio_oe = 1'b1;
          if (cmd == tsp_pkg::CMD_SHUTDOWN) begin
            next_shutdown = 1'b1;
            next_sio_out = ID_WORD[15];
            next_shreg = {ID_WORD[14:0], 1'b1};
          end else begin
            if (cmd == tsp_pkg::CMD_RUN) begin
              next_shutdown = 1'b0;
            end
            next_sio_out = temperature_result[15];
            next_shreg = {temperature_result[14:0], 1'b1};
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (cs_rise) begin
      next_sio_oe = 1'b0; // [R09]
    end
    if (srst) begin
      next_state = ST_IDLE; // [R01]
      next_shreg = '0;
      next_bitcnt = '0;
      next_cmd = '0;
      next_temperature_result = tsp_pkg::TEMP_RST;
      next_pend = 1'b0;
      next_shutdown = 1'b0;
      next_temp_valid = 1'b0;
      next_sio_out = 1'b0;
      next_sio_oe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    sck_d <= next_sck_d;
    cs_d <= next_cs_d;
    state <= next_state;
    shreg <= next_shreg;
    bitcnt <= next_bitcnt;
    cmd <= next_cmd;
    temperature_result <= next_temperature_result;
    pend <= next_pend;
    shutdown <= next_shutdown;
    temp_valid <= next_temp_valid;
    sio_out <= next_sio_out;
    sio_oe <= next_sio_oe;
  end

  chk_release_idle: assert property (@(posedge clk) disable iff (srst) // [R09]
    (cs_n_s && cs_d) |=> !sio_oe)
    else $error("data pin driven while deselected");

  chk_first_bit: assert property (@(posedge clk) disable iff (srst) // [R10]
    (state == ST_IDLE && cs_fall) |=> (sio_oe && sio_out == $past(load_word[15])))
    else $error("first bit not driven at select");

  chk_tail_ones: assert property (@(posedge clk) disable iff (srst) // [R04]
    temperature_result[1:0] == tsp_pkg::WORD_TAIL)
    else $error("low word bits not ones");

  chk_no_load_sel: assert property (@(posedge clk) disable iff (srst) // [R13]
    (!cs_n_s && !$past(cs_n_s)) |-> $stable(temperature_result))
    else $error("result changed while selected");

  chk_deferred_load: assert property (@(posedge clk) disable iff (srst) // [R13]
    (pend && cs_n_s) |=> (!pend && temperature_result == $past(fresh_word)))
    else $error("deferred result not loaded");

  chk_cmd_run: assert property (@(posedge clk) disable iff (srst) // [R15]
    (state == ST_IN && cs_n_s && bitcnt >= 5'h8 && cmd == 8'h00) |=> !shutdown)
    else $error("run command not taken");

  chk_cmd_stop: assert property (@(posedge clk) disable iff (srst) // [R15]
    (state == ST_IN && cs_n_s && bitcnt >= 5'h8 && cmd == 8'hff) |=> shutdown)
    else $error("shutdown command not taken");

  chk_id_out: assert property (@(posedge clk) disable iff (srst) // [R17]
    (state == ST_IDLE && cs_fall && shutdown) |=> sio_out == ID_WORD[15])
    else $error("identification word not sent");

  chk_valid_flag: assert property (@(posedge clk) disable iff (srst) // [R02]
    conv_done |=> temp_valid)
    else $error("valid flag not set after conversion");

  chk_end_clean: assert property (@(posedge clk) disable iff (srst) // [R12]
    (state == ST_OUT && cs_n_s) |=> (state == ST_IDLE && !sio_oe))
    else $error("frame not ended on deselect");

  chk_phase_switch: assert property (@(posedge clk) disable iff (srst) // [R08]
    (state == ST_OUT && !cs_n_s && sck_fall && bitcnt == 5'(tsp_pkg::PHASE_BITS))
    |=> (state == ST_IN && !sio_oe))
    else $error("output phase did not hand over to input");

  chk_out_shift: assert property (@(posedge clk) disable iff (srst) // [R05] [R06]
    (state == ST_OUT && !cs_n_s && sck_fall && bitcnt != 5'h0 && bitcnt != 5'(tsp_pkg::PHASE_BITS))
    |=> sio_out == $past(shreg[15]))
    else $error("next bit not shifted on falling edge");

  chk_hold_bit: assert property (@(posedge clk) disable iff (srst) // [R06]
    (state == ST_OUT && !cs_n_s && !sck_fall) |=> $stable(sio_out))
    else $error("output bit changed without falling edge");

  chk_in_shift: assert property (@(posedge clk) disable iff (srst) // [R14]
    (state == ST_IN && !cs_n_s && sck_rise && bitcnt != 5'(tsp_pkg::PHASE_BITS))
    |=> cmd == {$past(cmd[6:0]), $past(din_s)})
    else $error("input bit not taken on rising edge");

  chk_in_release: assert property (@(posedge clk) disable iff (srst) // [R08] [R09]
    state == ST_IN |-> !sio_oe)
    else $error("data pin driven during input phase");

  chk_short_cmd: assert property (@(posedge clk) disable iff (srst) // [R14]
    (state == ST_IN && cs_n_s && bitcnt < 5'(tsp_pkg::CMD_W)) |=> $stable(shutdown))
    else $error("short command changed the mode");

  chk_idle_quiet: assert property (@(posedge clk) disable iff (srst) // [R09]
    (state == ST_IDLE && !cs_fall) |=> !sio_oe)
    else $error("data pin driven while idle");

  chk_no_conv_stop: assert property (@(posedge clk) disable iff (srst) // [R15]
    shutdown |=> !conv_done)
    else $error("conversion finished in shutdown");

  chk_valid_hold: assert property (@(posedge clk) disable iff (srst) // [R02]
    temp_valid |=> temp_valid)
    else $error("valid flag dropped");

  chk_load_fresh: assert property (@(posedge clk) disable iff (srst) // [R23]
    (conv_done && cs_n_s && !pend) |=> temperature_result == $past(fresh_word))
    else $error("new result not loaded while deselected");

  chk_pend_set: assert property (@(posedge clk) disable iff (srst) // [R13]
    (conv_done && !cs_n_s) |=> pend)
    else $error("result during frame not held back");

  chk_restart_id: assert property (@(posedge clk) disable iff (srst) // [R19]
    (state == ST_IN && !cs_n_s && sck_fall && bitcnt == 5'(tsp_pkg::PHASE_BITS) && cmd == tsp_pkg::CMD_SHUTDOWN)
    |=> (state == ST_OUT && shutdown && sio_out == ID_WORD[15]))
    else $error("in-frame shutdown did not send identification");

  chk_cs_rise_off: assert property (@(posedge clk) disable iff (srst) // [R09]
    cs_rise |=> !sio_oe)
    else $error("data pin not released on deselect");
endmodule

// >>> hdl/tsp_pkg.sv
package tsp_pkg;
  localparam int TEMP_W = 14;
  localparam int WORD_W = 16;
  localparam int CMD_W = 8;
  localparam int PHASE_BITS = 16;
  localparam logic [1:0] WORD_TAIL = 2'h3;
  localparam logic [7:0] CMD_RUN = 8'h00;
  localparam logic [7:0] CMD_SHUTDOWN = 8'hff;
  // Arbitrary neutral identification value; low two bits stay ones
  localparam logic [15:0] ID_WORD_RST = 16'h5a53;
  localparam logic [15:0] TEMP_RST = 16'h0003;
  localparam real CLK_MHZ = 25.0;
  localparam real CONV_MS = 228.0;
  localparam int CONV_CYCLES = int'(CONV_MS * CLK_MHZ * 1000.0);
  localparam real CS_GAP_NS = 160.0;
  localparam int CS_GAP_CYCLES = int'(CS_GAP_NS * CLK_MHZ / 1000.0);
endpackage

// >>> hdl/tsp_sync.sv
`timescale 1ns/1ps
module tsp_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic din,
  input wire logic rst_val,
  output logic dout
);
  logic meta;
  logic next_meta;
  logic next_dout;

  always_comb begin
    next_meta = srst ? rst_val : din;
    next_dout = srst ? rst_val : meta;
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    dout <= next_dout;
  end
endmodule

// >>> hdl/tsp_converter.sv
`timescale 1ns/1ps
module tsp_converter #(
  parameter int CONV_CYCLES = tsp_pkg::CONV_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [tsp_pkg::TEMP_W-1:0] sample,
  output logic done,
  output logic [tsp_pkg::TEMP_W-1:0] result
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_done;
  logic [tsp_pkg::TEMP_W-1:0] next_result;

  // Back-to-back conversions while running; stopping restarts the interval
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    next_result = result;
    if (srst || !run) begin
      next_cnt = '0;
    end else if (cnt == 32'(CONV_CYCLES - 1)) begin
      next_cnt = '0;
      next_done = 1'b1;
      next_result = sample;
    end else begin
      next_cnt = cnt + 32'h1;
    end
    if (srst) begin
      next_result = '0;
    end
  end

  always_ff @(posedge clk) begin
    cnt <= next_cnt;
    done <= next_done;
    result <= next_result;
  end
endmodule

// >>> tb/tsp_host_model.sv
`timescale 1ns/1ps
module tsp_host_model (
  input wire logic clk,
  input wire logic sio_out,
  input wire logic sio_oe,
  output logic chip_sel_n,
  output logic serial_bit_clock,
  output logic sio_in
);
  logic drv;
  logic dat;
  logic last_drv = 1'b0;
  initial begin
    chip_sel_n = 1'b1;
    serial_bit_clock = 1'b0;
    drv = 1'b0;
    dat = 1'b0;
  end
  // No pull on the line: a released pin shows the opposite of the last driven bit, so stale data is caught
  always @(posedge clk) begin
    if (sio_oe === 1'b1) begin
      last_drv <= sio_out;
    end
  end
  assign sio_in = sio_oe ? sio_out : (drv ? dat : ~last_drv);

  task automatic select();
    @(negedge clk);
    chip_sel_n = 1'b0; // clock stands low here
    repeat (4) @(negedge clk);
  endtask

  task automatic deselect(input int hold_cyc);
    repeat (hold_cyc) @(negedge clk);
    chip_sel_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  // Output bits read late in the high phase, input bits set up in the low phase
  task automatic xfer(input int n_out, input int n_in, input logic [15:0] wr, output logic [15:0] rd,
                      output logic oe_ok);
    rd = '0;
    oe_ok = 1'b1;
    for (int i = 0; i < n_out; i++) begin
      serial_bit_clock = 1'b1;
      repeat (4) @(negedge clk);
      oe_ok = oe_ok & (sio_oe === 1'b1);
      rd = {rd[14:0], sio_in};
      serial_bit_clock = 1'b0;
      repeat (4) @(negedge clk);
    end
    for (int i = 0; i < n_in; i++) begin
      drv = 1'b1;
      dat = wr[n_in-1-i];
      repeat (4) @(negedge clk);
      serial_bit_clock = 1'b1;
      repeat (4) @(negedge clk);
      serial_bit_clock = 1'b0;
    end
    drv = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int CONV = 200;
  // Arbitrary value, low two bits ones
  localparam logic [15:0] ID = 16'h6a97;
  logic clk, srst, chip_sel_n, serial_bit_clock, sio_in, sio_out, sio_oe, shutdown, temp_valid;
  logic [13:0] sample;
  logic [15:0] rd, rd2, word;
  logic ok;
  int n_fail, tests_run;

  tsp_port #(.CONV_CYCLES(CONV), .ID_WORD(ID)) DUT (.clk(clk), .srst(srst), .chip_sel_n(chip_sel_n),
    .serial_bit_clock(serial_bit_clock), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe),
    .sensor_sample(sample), .shutdown(shutdown), .temp_valid(temp_valid));
  tsp_host_model host (.clk(clk), .sio_out(sio_out), .sio_oe(sio_oe), .chip_sel_n(chip_sel_n),
    .serial_bit_clock(serial_bit_clock), .sio_in(sio_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic read_word(input int n, output logic [15:0] r);
    host.select();
    host.xfer(n, 0, 16'h0000, r, ok);
    host.deselect(0);
  endtask

  task automatic t_first_read();
    read_word(16, rd);
    cmp16(rd, 16'h0003);
    cmp1(temp_valid, 1'b0);
    cmp1(ok, 1'b1);
    cmp1(shutdown, 1'b0);
    cmp1(sio_oe, 1'b0);
  endtask

  task automatic t_temp_and_abort();
    for (int i = 0; i < 1000 && temp_valid !== 1'b1; i++) begin
      @(negedge clk);
    end
    if (temp_valid !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t no conversion result in time", $time);
      tally_and_finish();
    end
    word = {sample, 2'b11};
    read_word(16, rd);
    cmp16(rd, word);
    read_word(4, rd);
    cmp16(rd, {12'h000, word[15:12]});
    cmp1(sio_oe, 1'b0);
    read_word(16, rd);
    cmp16(rd, word);
  endtask

  task automatic t_defer();
    host.select();
    // Changed only once selected, so a result carrying it that finishes before deselect must be held back
    sample = 14'h0321;
    host.xfer(16, 0, 16'h0000, rd, ok);
    host.deselect(300);
    cmp16(rd, word);
    read_word(16, rd);
    word = {sample, 2'b11};
    cmp16(rd, word);
  endtask

  task automatic t_modes();
    host.select();
    host.xfer(16, 16, 16'h12ff, rd, ok);
    host.deselect(0);
    cmp1(shutdown, 1'b1);
    host.select();
    host.xfer(16, 4, 16'h0000, rd, ok);
    host.deselect(0);
    cmp1(shutdown, 1'b1);
    read_word(16, rd);
    cmp16(rd, ID);
    host.select();
    host.xfer(16, 8, 16'h0000, rd, ok);
    host.deselect(0);
    cmp1(shutdown, 1'b0);
    repeat (CONV + 20) @(negedge clk);
    host.select();
    host.xfer(16, 16, 16'hffff, rd, ok);
    host.xfer(16, 8, 16'h0000, rd2, ok);
    host.deselect(0);
    cmp16(rd, word);
    cmp16(rd2, ID);
    cmp1(shutdown, 1'b0);
  endtask

  initial begin
    n_fail = 0;
    tests_run = 0;
    srst = 1'b1;
    sample = 14'h2c71;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    t_first_read();
    t_temp_and_abort();
    t_defer();
    t_modes();
    tally_and_finish();
  end
endmodule
